/* core/interrupt_shadow_status_regs.sv */
// Operation
// R1: Ext irq 2..0 edge polarity: 1 rising
// R2: Seven 4-bit level shadow fields, 7 top
// R3: Field 0001 shadow set 1, 0000 set 0
// R4: Level fields ignored in single-vector mode
// R5: Bit 0 gives single vector shadow set
// R6: Status 10-8 hold latest presented level
// R7: Status 7-0 hold last serviced number
// R8: Software trusts level only in single-vector
// R9: Unimplemented status and shadow bits read 0
// R10: Proximity reload is 32-bit, resets zero
// R11: Reload loads timer on each trigger
// R12: Control bit 12 selects multi-vector mode
// R13: Threshold N: levels N or lower start timer; here level 0 never does, and N=0 disables it
// R14: Timer counts down to zero then stops
//
// Chosen here: the address map and the AXI4-Lite slave port.
module interrupt_shadow_status_regs #(
  parameter int TIMER_W = 32                    // Proximity timer width
) (
  input  wire logic                     aclk,          // System clock
  input  wire logic                     aresetn,       // Sync reset, low
  input  wire logic [3:0]               s_axi_awaddr,  // Write address
  input  wire logic                     s_axi_awvalid, // Write addr valid
  output logic                          s_axi_awready, // Write addr ready
  input  wire logic [31:0]              s_axi_wdata,   // Write data
  input  wire logic [3:0]               s_axi_wstrb,   // Byte enables
  input  wire logic                     s_axi_wvalid,  // Write data valid
  output logic                          s_axi_wready,  // Write data ready
  output logic [1:0]                    s_axi_bresp,   // Write response
  output logic                          s_axi_bvalid,  // Response valid
  input  wire logic                     s_axi_bready,  // Response ready
  input  wire logic [3:0]               s_axi_araddr,  // Read address
  input  wire logic                     s_axi_arvalid, // Read addr valid
  output logic                          s_axi_arready, // Read addr ready
  output logic [31:0]                   s_axi_rdata,   // Read data
  output logic [1:0]                    s_axi_rresp,   // Read response
  output logic                          s_axi_rvalid,  // Read data valid
  input  wire logic                     s_axi_rready,  // Read data ready
  input  wire irq_shadow_pkg::irq_event_s presented,   // Irq sent to CPU
  input  wire irq_shadow_pkg::irq_event_s serviced,    // Irq CPU serviced
  output logic [2:0]                    ext_irq_rising,  // Edge per input
  output logic                          multi_vector_select, // Vector mode
  output logic                          shadow_set_sel,  // Set for presented
  output logic                          prox_active,     // Timer running
  output logic [TIMER_W-1:0]            prox_count       // Timer value
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  // The timer reloads from one bus word, so it can be no wider than that
  if (TIMER_W < 1 || TIMER_W > 32) begin : g_bad_timer_w
    $error("TIMER_W must be 1 to 32");
  end

  // The level decode below has one shadow field per level 7 down to 1
  if (irq_shadow_pkg::NUM_LEVELS != 7
      || irq_shadow_pkg::FIELD_W != 4) begin : g_bad_fields
    $error("Shadow select layout must be seven 4-bit fields");
  end

  // Edge-select outputs are a slice of the low control byte
  if (irq_shadow_pkg::NUM_EXT != 3) begin : g_bad_ext
    $error("Three external edge selects are wired to the outputs");
  end

  logic [31:0]        irq_control_reg_r;
  logic [31:0]        level_shadow_select_reg_r;
  logic [2:0]         latest_presented_level_r;
  logic [7:0]         last_serviced_irq_number_r;
  logic [31:0]        proximity_reload_reg_r;
  logic [TIMER_W-1:0] prox_count_r;
  logic               aw_held_r;
  logic               w_held_r;
  logic [3:0]         awaddr_r;
  logic [31:0]        wdata_r;
  logic [3:0]         wstrb_r;
  logic               do_write;
  logic [2:0]         proximity_threshold;
  logic               prox_trigger;
  logic               wr_control;
  logic               wr_shadow;
  logic               wr_reload;
  logic               wr_error;
  logic [31:0]        status_word;
  logic [31:0]        read_word;
  logic [7:1]         level_uses_set1;
  logic               single_vector_set;
  logic               timer_enabled;
  logic               level_in_window;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb,
                                        input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    // Masking after the merge keeps unimplemented bits at 0
    return res & mask;
  endfunction

  function automatic logic mapped(input logic [3:0] addr);
    return addr == irq_shadow_pkg::CONTROL_OFS
        || addr == irq_shadow_pkg::SHADOW_OFS
        || addr == irq_shadow_pkg::STATUS_OFS
        || addr == irq_shadow_pkg::RELOAD_OFS;
  endfunction

  // One level's shadow field: level 1 in bits 7:4, level 7 at the top
  function automatic logic [3:0] level_field(input logic [31:0] sel,
                                             input logic [2:0]  level);
    return sel[level * irq_shadow_pkg::FIELD_W +: irq_shadow_pkg::FIELD_W];
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  // Address and data are latched independently, so either may come first
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign do_write      = aw_held_r && w_held_r && !s_axi_bvalid;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign wr_control = do_write && awaddr_r == irq_shadow_pkg::CONTROL_OFS;
  assign wr_shadow  = do_write && awaddr_r == irq_shadow_pkg::SHADOW_OFS;
  assign wr_reload  = do_write && awaddr_r == irq_shadow_pkg::RELOAD_OFS;
  // Status is read-only, so a write to it is refused like a hole
  assign wr_error   = !mapped(awaddr_r)
                      || awaddr_r == irq_shadow_pkg::STATUS_OFS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // The code is only looked at while bvalid stands, and do_write cannot
  // recur before the response is taken, so it needs no hold term
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= irq_shadow_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bresp <= wr_error ? irq_shadow_pkg::RESP_SLVERR
                              : irq_shadow_pkg::RESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_control_reg_r <= irq_shadow_pkg::RESET_VALUE;
    end else if (wr_control) begin
      irq_control_reg_r <= merge(irq_control_reg_r, wdata_r, wstrb_r,
                                 irq_shadow_pkg::CONTROL_MASK); // R1 R12
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_shadow_select_reg_r <= irq_shadow_pkg::RESET_VALUE;
    end else if (wr_shadow) begin
      level_shadow_select_reg_r <= merge(level_shadow_select_reg_r,
                                         wdata_r, wstrb_r,
                                         irq_shadow_pkg::SHADOW_MASK); // R9
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      proximity_reload_reg_r <= irq_shadow_pkg::RESET_VALUE; // R10
    end else if (wr_reload) begin
      proximity_reload_reg_r <= merge(proximity_reload_reg_r, wdata_r,
                                      wstrb_r, 32'hFFFF_FFFF); // R10
    end
  end

  // ----------------------------------------------------------------
  // Hardware status
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latest_presented_level_r <= 3'h0;
    end else if (presented.valid) begin
      // Kept in multi-vector mode too; software decides when it applies
      latest_presented_level_r <= presented.level; // R6
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_serviced_irq_number_r <= 8'h00;
    end else if (serviced.valid) begin
      // Only the number is kept; a serviced irq's level is not reported
      last_serviced_irq_number_r <= serviced.number; // R7
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  // Next read is refused until this one is taken
  assign s_axi_arready = !s_axi_rvalid;

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  assign status_word = {21'h00_0000,                 // R9
                        latest_presented_level_r,    // R6
                        last_serviced_irq_number_r}; // R7

  always_comb begin
    unique case (s_axi_araddr)
      irq_shadow_pkg::CONTROL_OFS: read_word = irq_control_reg_r;
      irq_shadow_pkg::SHADOW_OFS:  read_word = level_shadow_select_reg_r;
      irq_shadow_pkg::STATUS_OFS:  read_word = status_word;
      irq_shadow_pkg::RELOAD_OFS:  read_word = proximity_reload_reg_r;
      default:                     read_word = 32'h0000_0000; // R9
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Data and code are captured with the address, so rdata stands as long
  // as rvalid does even if the master changes araddr meanwhile
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= irq_shadow_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= read_word;
      s_axi_rresp <= mapped(s_axi_araddr) ? irq_shadow_pkg::RESP_OKAY
                                          : irq_shadow_pkg::RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  assign ext_irq_rising =
    irq_control_reg_r[irq_shadow_pkg::NUM_EXT-1:0]; // R1
  assign multi_vector_select =
    irq_control_reg_r[irq_shadow_pkg::MULTI_VEC_BIT]; // R12
  assign proximity_threshold =
    irq_control_reg_r[irq_shadow_pkg::THRESHOLD_LSB +: 3];

  // ----------------------------------------------------------------
  // Shadow set decode
  // ----------------------------------------------------------------
  // Reserved field codes fall back to set 0 rather than undefined state
  for (genvar l = 1; l <= irq_shadow_pkg::NUM_LEVELS; l++) begin : g_level
    assign level_uses_set1[l] =
      level_field(level_shadow_select_reg_r, 3'(l))
      == irq_shadow_pkg::SHADOW_SET1; // R2 R3
  end

  assign single_vector_set =
    level_shadow_select_reg_r[irq_shadow_pkg::SV_SHADOW_BIT]; // R5

  // Level 0 has no field of its own and runs on set 0 in multi-vector mode
  always_comb begin
    if (!multi_vector_select) begin
      shadow_set_sel = single_vector_set; // R4 R5
    end else if (presented.level == 3'h0) begin
      shadow_set_sel = 1'b0;
    end else begin
      shadow_set_sel = level_uses_set1[presented.level]; // R2 R3
    end
  end

  // ----------------------------------------------------------------
  // Proximity timer
  // ----------------------------------------------------------------
  assign timer_enabled   = proximity_threshold != 3'h0;
  assign level_in_window = presented.level != 3'h0
                           && presented.level <= proximity_threshold;
  assign prox_trigger    = presented.valid && timer_enabled
                           && level_in_window; // R13

  // A new trigger reloads even mid-count, so a burst stretches the window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prox_count_r <= '0;
    end else if (prox_trigger) begin
      prox_count_r <= proximity_reload_reg_r[TIMER_W-1:0]; // R11
    end else if (prox_count_r != '0) begin
      prox_count_r <= prox_count_r - 1'b1; // R14
    end
  end

  // ----------------------------------------------------------------
  // Timer outputs
  // ----------------------------------------------------------------
  assign prox_count  = prox_count_r;
  assign prox_active = prox_count_r != '0;

endmodule

/* core/irq_shadow_pkg.sv */
package irq_shadow_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] CONTROL_OFS = 4'h0;
  localparam logic [3:0] SHADOW_OFS  = 4'h4;
  localparam logic [3:0] STATUS_OFS  = 4'h8;
  localparam logic [3:0] RELOAD_OFS  = 4'hC;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          MULTI_VEC_BIT = 12;
  localparam int          THRESHOLD_LSB = 8;
  localparam int          LEVEL_LSB     = 8;
  localparam int          NUM_EXT       = 3;
  localparam int          FIELD_W       = 4;
  localparam int          NUM_LEVELS    = 7;
  localparam int          SV_SHADOW_BIT = 0;
  localparam logic [31:0] CONTROL_MASK  = 32'h0000_1707;
  localparam logic [31:0] SHADOW_MASK   = 32'hFFFF_FFF1;
  localparam logic [31:0] RESET_VALUE   = 32'h0000_0000;
  localparam logic [3:0]  SHADOW_SET1   = 4'h1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Interrupt event reported by the arbitration logic
  typedef struct packed {
    logic       valid;
    logic [2:0] level;
    logic [7:0] number;
  } irq_event_s;

endpackage

/* dv/cpu_core_model.sv */
module cpu_core_model (
  input  wire logic                  aclk,      // Clock
  output irq_shadow_pkg::irq_event_s presented, // Given
  output irq_shadow_pkg::irq_event_s serviced   // Taken
);
  timeunit 1ns;
  timeprecision 1ps;
  initial presented = '0;
  initial serviced = '0;
  // One-cycle pulses; the #1 lets the clearing edge's updates land
  task automatic present(input logic [2:0] l, input logic [7:0] n);
    @(posedge aclk);
    presented <= '{1'b1, l, n};
    @(posedge aclk);
    presented <= '0;
    #1;
  endtask
  task automatic service(input logic [7:0] n);
    @(posedge aclk);
    serviced <= '{1'b1, 3'h0, n};
    @(posedge aclk);
    serviced <= '0;
    #1;
  endtask
endmodule

/* dv/irq_shadow_sva.sv */
module irq_shadow_sva #(
  parameter int TIMER_W = 32 // Timer width
) (
  input wire logic               aclk,          // Clock
  input wire logic               aresetn,       // Reset
  input wire logic [3:0]         s_axi_awaddr,  // Addr
  input wire logic               s_axi_awvalid, // Valid
  input wire logic               s_axi_awready, // Ready
  input wire logic               s_axi_wvalid,  // Valid
  input wire logic               s_axi_wready,  // Ready
  input wire logic [1:0]         s_axi_bresp,   // Resp
  input wire logic               s_axi_bvalid,  // Valid
  input wire logic               s_axi_bready,  // Ready
  input wire logic               s_axi_arvalid, // Valid
  input wire logic               s_axi_arready, // Ready
  input wire logic [31:0]        s_axi_rdata,   // Data
  input wire logic               s_axi_rvalid,  // Valid
  input wire logic               s_axi_rready,  // Ready
  input wire irq_shadow_pkg::irq_event_s presented, // Event
  input wire logic               prox_active,   // Running
  input wire logic [TIMER_W-1:0] prox_count     // Count
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic wboth;
  assign wboth = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                 && s_axi_wready;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_lat: assert property (wboth |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_status_ro:
    assert property (wboth && s_axi_awaddr == 4'h8 |-> ##2
      s_axi_bresp == irq_shadow_pkg::RESP_SLVERR)
    else $error("status write accepted");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read response late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_prox_down:
    assert property (prox_active && !presented.valid
      |=> prox_count == $past(prox_count) - 1'b1)
    else $error("timer not counting down");
  a_prox_idle:
    assert property (!prox_active && !presented.valid |=> !prox_active)
    else $error("timer started by itself");
endmodule

/* dv/test_interrupt_shadow_status_regs.sv */
module test_interrupt_shadow_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, multi_vector_select;
  logic shadow_set_sel, prox_active, seen_sel;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, prox_count;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_rresp;
  logic [2:0] ext_irq_rising;
  irq_shadow_pkg::irq_event_s presented, serviced;
  int fail_count = 0, checks = 0;
  interrupt_shadow_status_regs uut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .presented,
    .serviced, .ext_irq_rising, .multi_vector_select, .shadow_set_sel,
    .prox_active, .prox_count);
  cpu_core_model m (.aclk, .presented, .serviced);
  initial begin
    aclk = 0;
    forever #10 aclk = ~aclk;
  end
  // Shadow select is combinational, so catch it mid-pulse
  always @(negedge aclk) if (presented.valid) seen_sel <= shadow_set_sel;
  task automatic chk(input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wc(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw, w, ta, tw;
    logic [1:0] r;
    aw = 1;
    w = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (aw || w) begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      @(posedge aclk);
      aw &= !ta;
      w &= !tw;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    // Late ready makes the slave hold its answer a cycle
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1;
    do begin
      @(negedge aclk);
      ta = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
    end while (!ta);
    s_axi_bready <= 0;
    chk(32'(r), 32'(er));
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    logic t;
    logic [31:0] d;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end while (!t);
    s_axi_arvalid <= 0;
    @(posedge aclk);
    s_axi_rready <= 1;
    do begin
      @(negedge aclk);
      t = s_axi_rvalid;
      d = s_axi_rdata;
      last_rresp = s_axi_rresp;
      @(posedge aclk);
    end while (!t);
    s_axi_rready <= 0;
    chk(d, e);
  endtask
  task automatic conclude;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    conclude();
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    aresetn = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 16; i += 4) rc(4'(i), '0);
    chk(32'(last_rresp), 32'h0);
    rc(4'h2, 32'h0);
    chk(32'(last_rresp), 32'h2);
    wc(4'h2, 32'hFFFF_FFFF, 2'h2);
    wc(4'h0, 32'hFFFF_FFFF, 2'h0);
    rc(4'h0, 32'h0000_1707);
    chk(32'(ext_irq_rising), 32'h7);
    chk(32'(multi_vector_select), 32'h1);
    wc(4'h0, 32'h0000_0005, 2'h0);
    chk(32'(ext_irq_rising), 32'h5);
    wc(4'h4, 32'hFFFF_FFFF, 2'h0);
    rc(4'h4, 32'hFFFF_FFF1);
    wc(4'h4, 32'h1111_1110, 2'h0);
    m.present(3'h3, 8'h3C);
    chk(32'(seen_sel), 32'h0);
    m.service(8'hA7);
    rc(4'h8, 32'h0000_03A7);
    wc(4'h8, 32'hFFFF_FFFF, 2'h2);
    rc(4'h8, 32'h0000_03A7);
    wc(4'h4, 32'h0000_0001, 2'h0);
    m.present(3'h6, 8'h01);
    chk(32'(seen_sel), 32'h1);
    wc(4'h0, 32'h0000_1000, 2'h0);
    for (int l = 1; l < 8; l++) begin
      wc(4'h4, 32'h1 << (4 * l), 2'h0);
      m.present(3'(l), 8'h00);
      chk(32'(seen_sel), 32'h1);
      m.present(3'(l % 7 + 1), 8'h00);
      chk(32'(seen_sel), 32'h0);
    end
    wc(4'h4, 32'h2000_0001, 2'h0);
    m.present(3'h7, 8'h00);
    chk(32'(seen_sel), 32'h0);
    m.present(3'h0, 8'h00);
    chk(32'(seen_sel), 32'h0);
    wc(4'h0, 32'h0000_1300, 2'h0);
    wc(4'hC, 32'h0000_0005, 2'h0);
    m.present(3'h3, 8'h00);
    chk(prox_count, 32'h5);
    repeat (5) @(posedge aclk);
    #1 chk(32'(prox_active), 32'h0);
    m.present(3'h4, 8'h00);
    chk(prox_count, 32'h0);
    wc(4'h0, 32'h0000_1000, 2'h0);
    m.present(3'h1, 8'h00);
    chk(prox_count, 32'h0);
    wc(4'hC, 32'hFFFF_FFFF, 2'h0);
    rc(4'hC, 32'hFFFF_FFFF);
    wc(4'hC, 32'h0, 2'h0);
    s_axi_wstrb <= 4'h1;
    wc(4'hC, 32'hFFFF_FFFF, 2'h0);
    s_axi_wstrb <= 4'hF;
    rc(4'hC, 32'h0000_00FF);
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rc(4'hC, 32'h0);
    conclude();
  end
endmodule
bind interrupt_shadow_status_regs irq_shadow_sva #(.TIMER_W(TIMER_W))
  sva_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .presented, .prox_active, .prox_count);
